//--- rtl/flash_rw_pkg.sv
// package: constants, register map and state type of the flash rewrite interrupt controller
package flash_rw_pkg;
	// ==========================================================
	// timing
	localparam int CLOCK_PERIOD_NS = 40; // 25 mhz system clock
	localparam int SUSPEND_LATENCY_NS = 20000; // suspend latency, plain default
	localparam int RESTART_NS = 10000; // fixed flash restart period after a forced reset, plain default
	// least times round up to whole cycles
	localparam logic [15:0] SUSPEND_CYC = 16'((SUSPEND_LATENCY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	localparam logic [15:0] RESTART_CYC = 16'((RESTART_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

	// ==========================================================
	// register map (byte addresses, one word each)
	typedef logic [4:0] addr_t;
	localparam addr_t CTRL_A_OFS = 5'h00; // flash_ctrl_reg_a
	localparam addr_t CTRL_B_OFS = 5'h04; // flash_ctrl_reg_b
	localparam addr_t CTRL_C_OFS = 5'h08; // flash_ctrl_reg_c
	localparam addr_t STATUS_OFS = 5'h0c; // read-only state
	localparam addr_t COMMAND_OFS = 5'h10; // start of an auto operation
	localparam logic [7:0] CTRL_A_RST = 8'h00;
	localparam logic [7:0] CTRL_B_RST = 8'h00;
	localparam logic [7:0] CTRL_C_RST = 8'h00;

	// ==========================================================
	// field positions
	localparam int A1_BIT = 1; // protected_bit_a1: cpu rewrite enable
	localparam int A2_BIT = 2; // protected_bit_a2: command lock
	localparam int ROM_EXEC_BIT = 1; // rewrite_mode_rom_exec (0 = rewrite_mode_ram_exec)
	localparam int ESR_BIT = 1; // erase_suspend_request
	localparam int SIE_BIT = 2; // suspend_on_interrupt_enable
	// writable bits and protected bits per register
	localparam logic [7:0] A_WMASK = 8'h06;
	localparam logic [7:0] B_WMASK = 8'hfa;
	localparam logic [7:0] C_WMASK = 8'h87;
	localparam logic [7:0] A_SETP = 8'h06; // a1, a2
	localparam logic [7:0] B_SETP = 8'h08; // b3
	localparam logic [7:0] C_SETP = 8'h85; // c0, c2 (suspend enable), c7
	localparam logic [7:0] A_CLRP = 8'h00;
	localparam logic [7:0] B_CLRP = 8'hf0; // b4..b7
	localparam logic [7:0] C_CLRP = 8'h00;
	// command word
	localparam int CMD_START_BIT = 0;
	localparam int CMD_PROG_BIT = 1; // 0 erase, 1 program
	localparam int CMD_PROM_BIT = 2; // 0 data flash, 1 program rom
	localparam int CMD_BLOCK_LSB = 8;
	// status word
	localparam int ST_BUSY = 0;
	localparam int ST_SUSP = 1;
	localparam int ST_ABORT = 2;
	localparam int ST_DONE = 3;
	localparam int ST_HOLD = 4;
	localparam int ST_RESTART = 5;

	// ==========================================================
	typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_SUSP_WAIT, ST_SUSPENDED, ST_RST_WAIT} state_t;
endpackage

//--- rtl/flash_delay_timer.sv
// down counter that times the suspend latency and the flash restart period
`timescale 1ns/100ps
`default_nettype none
module flash_delay_timer (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic load, // start a new interval
	input wire logic [15:0] count, // interval length in cycles
	output logic done // high in the last cycle of the interval
);
	logic [15:0] cnt_r; // remaining cycles, zero when idle
	logic [15:0] cnt_nxt;

	// ==========================================================
	// next value: load wins, otherwise count down to zero
	always_comb begin
		cnt_nxt = cnt_r;
		if (load) begin
			cnt_nxt = count;
		end else if (cnt_r != 16'h0000) begin
			cnt_nxt = cnt_r - 16'h0001;
		end
	end

	// register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 16'h0000;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// the owner leaves its wait state on the edge after this
	assign done = (cnt_r == 16'h0001);
endmodule
`default_nettype wire

//--- rtl/flash_rewrite_interrupt_control.sv
// flash rewrite controller: erase suspend, interrupt hold, forced abort and protected control bits
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - interrupt during data erase auto-sets suspend request
// - suspend request halts erase after latency
// - suspended: read all blocks except erased one
// - clearing suspend request resumes the erase
// - data flash unsuspended or programming: interrupts run
// - rom mode suspend: suspend first, then interrupt
// - rom mode otherwise: hold interrupts until done
// - non-maskable event aborts rom operation, resets flash
// - watchdog keeps counting; refresh during suspend
module flash_rewrite_interrupt_control (
	input wire logic clock,
	input wire logic nrst,
	// avalon-mm slave
	input wire flash_rw_pkg::addr_t address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// cpu side interrupt path
	input wire logic irq_req, // maskable request pending at the controller
	input wire logic irq_ack, // cpu acknowledged a maskable interrupt
	input wire logic nmi_event, // watchdog, oscillation stop, voltage monitor or nmi
	output logic irq_hold, // keep maskable requests pending
	output logic nmi_hold, // keep non-maskable handling back until restart
	// flash read check
	input wire logic [7:0] rd_block,
	output logic read_ok,
	// flash array
	input wire logic array_done, // auto operation finished
	output logic array_run,
	output logic array_prog,
	output logic array_target_prom,
	output logic [7:0] array_block,
	output logic array_halt,
	output logic array_reset
);
	import flash_rw_pkg::*;

	// ==========================================================
	// reset release through two flops
	logic [1:0] rst_sync_r; // rst_sync_r[0] only feeds rst_sync_r[1]
	logic rst_n;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// ==========================================================
	// helpers
	function automatic logic hit(input addr_t a, input addr_t ofs);
		hit = (a == ofs);
	endfunction

	// applies a write under the back-to-back protection scheme
	function automatic logic [7:0] prot_write(input logic [7:0] cur, input logic [7:0] wd,
			input logic [7:0] prev, input logic [7:0] wmask, input logic [7:0] setp, input logic [7:0] clrp);
		logic [7:0] res;
		res = (cur & ~wmask) | (wd & wmask);
		res = (res & ~setp) | (setp & wd & (cur | ~prev));
		res = (res & ~clrp) | (clrp & (wd | (cur & ~prev)));
		prot_write = res;
	endfunction

	// ==========================================================
	// avalon slave: one wait state on every access
	logic ack_r; // second cycle of an access
	logic ack_nxt;
	logic [31:0] readdata_r;
	logic [31:0] rd_nxt;
	logic wr_fire; // write takes effect this edge
	logic [31:0] rd_mux;
	logic [7:0] a_r, b_r, c_r; // control registers
	state_t state_r, state_nxt;
	logic prog_r, prom_r, abort_r, done_r;
	logic [7:0] block_r;
	logic busy;

	assign waitrequest = (read | write) & ~ack_r;
	assign wr_fire = write & ack_r & byteenable[0];
	assign readdata = readdata_r;
	assign busy = (state_r == ST_RUN) | (state_r == ST_SUSP_WAIT) | (state_r == ST_SUSPENDED);

	// read mux; unmapped addresses read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit(address, CTRL_A_OFS)) begin
			rd_mux[7:0] = a_r;
		end else if (hit(address, CTRL_B_OFS)) begin
			rd_mux[7:0] = b_r;
		end else if (hit(address, CTRL_C_OFS)) begin
			rd_mux[7:0] = c_r;
		end else if (hit(address, STATUS_OFS)) begin
			rd_mux[ST_BUSY] = busy;
			rd_mux[ST_SUSP] = (state_r == ST_SUSPENDED);
			rd_mux[ST_ABORT] = abort_r;
			rd_mux[ST_DONE] = done_r;
			rd_mux[ST_HOLD] = irq_hold;
			rd_mux[ST_RESTART] = (state_r == ST_RST_WAIT);
		end else if (hit(address, COMMAND_OFS)) begin
			rd_mux[CMD_START_BIT] = busy;
			rd_mux[CMD_PROG_BIT] = prog_r;
			rd_mux[CMD_PROM_BIT] = prom_r;
			rd_mux[CMD_BLOCK_LSB +: 8] = block_r;
		end
	end

	// read data is captured in the first cycle so it stands at the answering edge
	always_comb begin
		ack_nxt = (read | write) & ~ack_r;
		rd_nxt = readdata_r;
		if (read & ~ack_r) begin
			rd_nxt = rd_mux;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
			readdata_r <= 32'h0000_0000;
		end else begin
			ack_r <= ack_nxt;
			readdata_r <= rd_nxt;
		end
	end

	// ==========================================================
	// control registers and their write history
	logic [7:0] a_nxt, b_nxt, c_nxt;
	logic [7:0] pa_r, pb_r, pc_r, pa_nxt, pb_nxt, pc_nxt; // last value written
	logic [2:0] hist_r, hist_nxt; // per register: history valid, no interrupt since its last write
	logic esr_set; // hardware suspend request
	logic rom_exec, sie, esr;

	assign rom_exec = b_r[ROM_EXEC_BIT];
	assign sie = c_r[SIE_BIT];
	assign esr = c_r[ESR_BIT];
	// auto suspend only on an acknowledged data flash interrupt, or a held rom one;
	// a software trap never reaches irq_ack here, so it never auto-suspends
	assign esr_set = (state_r == ST_RUN) & ~prog_r & sie &
		((~prom_r & irq_ack) | (prom_r & rom_exec & irq_req));

	always_comb begin
		logic [7:0] qa, qb, qc; // effective previous values
		// without history the previous value counts as the protected level, so a lone write can neither set a set-protected bit nor clear a clear-protected one
		qa = hist_r[0] ? pa_r : A_SETP;
		qb = hist_r[1] ? pb_r : B_SETP;
		qc = hist_r[2] ? pc_r : C_SETP;
		a_nxt = a_r;
		b_nxt = b_r;
		c_nxt = c_r;
		pa_nxt = pa_r;
		pb_nxt = pb_r;
		pc_nxt = pc_r;
		hist_nxt = hist_r;
		if (wr_fire & hit(address, CTRL_A_OFS)) begin
			a_nxt = prot_write(a_r, writedata[7:0], qa, A_WMASK, A_SETP, A_CLRP);
			pa_nxt = writedata[7:0];
			hist_nxt[0] = 1'b1;
		end
		if (wr_fire & hit(address, CTRL_B_OFS)) begin
			b_nxt = prot_write(b_r, writedata[7:0], qb, B_WMASK, B_SETP, B_CLRP);
			pb_nxt = writedata[7:0];
			hist_nxt[1] = 1'b1;
		end
		if (wr_fire & hit(address, CTRL_C_OFS)) begin
			c_nxt = prot_write(c_r, writedata[7:0], qc, C_WMASK, C_SETP, C_CLRP);
			pc_nxt = writedata[7:0];
			hist_nxt[2] = 1'b1;
		end
		// an interrupt between the two writes spoils every pair
		if (irq_ack) begin
			hist_nxt = 3'b000;
		end
		// hardware set wins over a software clear in the same cycle
		if (esr_set) begin
			c_nxt[ESR_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			a_r <= CTRL_A_RST;
			b_r <= CTRL_B_RST;
			c_r <= CTRL_C_RST;
			pa_r <= CTRL_A_RST;
			pb_r <= CTRL_B_RST;
			pc_r <= CTRL_C_RST;
			hist_r <= 3'b000;
		end else begin
			a_r <= a_nxt;
			b_r <= b_nxt;
			c_r <= c_nxt;
			pa_r <= pa_nxt;
			pb_r <= pb_nxt;
			pc_r <= pc_nxt;
			hist_r <= hist_nxt;
		end
	end

	// ==========================================================
	// operation sequencer
	logic prog_nxt, prom_nxt, abort_nxt, done_nxt, reset_r, reset_nxt;
	logic [7:0] block_nxt;
	logic tmr_load, tmr_done, abort_ev, cmd_start;
	logic [15:0] tmr_val;

	assign cmd_start = wr_fire & hit(address, COMMAND_OFS) & writedata[CMD_START_BIT] & a_r[A1_BIT] & ~a_r[A2_BIT];
	// the watchdog is not stopped by a command, so it too aborts a rom operation
	assign abort_ev = nmi_event & prom_r & busy;

	always_comb begin
		state_nxt = state_r;
		prog_nxt = prog_r;
		prom_nxt = prom_r;
		block_nxt = block_r;
		abort_nxt = abort_r;
		done_nxt = done_r;
		reset_nxt = 1'b0;
		tmr_load = 1'b0;
		tmr_val = SUSPEND_CYC;
		case (state_r)
			ST_IDLE: begin
				if (cmd_start) begin
					state_nxt = ST_RUN;
					prog_nxt = writedata[CMD_PROG_BIT];
					prom_nxt = writedata[CMD_PROM_BIT];
					block_nxt = writedata[CMD_BLOCK_LSB +: 8];
					abort_nxt = 1'b0;
					done_nxt = 1'b0;
				end
			end
			ST_RUN: begin
				if (array_done) begin
					state_nxt = ST_IDLE;
					done_nxt = 1'b1;
				end else if (~prog_r & esr) begin
					state_nxt = ST_SUSP_WAIT;
					tmr_load = 1'b1;
				end
			end
			ST_SUSP_WAIT: begin
				if (array_done) begin
					state_nxt = ST_IDLE;
					done_nxt = 1'b1;
				end else if (tmr_done) begin
					state_nxt = ST_SUSPENDED;
				end
			end
			ST_SUSPENDED: begin
				if (~esr) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RST_WAIT: begin
				if (tmr_done) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		// forced abort overrides every busy state; the block stays marked bad
		if (abort_ev) begin
			state_nxt = ST_RST_WAIT;
			abort_nxt = 1'b1;
			done_nxt = 1'b0;
			reset_nxt = 1'b1;
			tmr_load = 1'b1;
			tmr_val = RESTART_CYC;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			prog_r <= 1'b0;
			prom_r <= 1'b0;
			block_r <= 8'h00;
			abort_r <= 1'b0;
			done_r <= 1'b0;
			reset_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			prog_r <= prog_nxt;
			prom_r <= prom_nxt;
			block_r <= block_nxt;
			abort_r <= abort_nxt;
			done_r <= done_nxt;
			reset_r <= reset_nxt;
		end
	end

	flash_delay_timer u_timer (
		.clock(clock),
		.rst_n(rst_n),
		.load(tmr_load),
		.count(tmr_val),
		.done(tmr_done)
	);

	// ==========================================================
	// outputs
	assign array_run = (state_r == ST_RUN) | (state_r == ST_SUSP_WAIT);
	assign array_halt = (state_r == ST_SUSPENDED);
	assign array_prog = prog_r;
	assign array_target_prom = prom_r;
	assign array_block = block_r;
	assign array_reset = reset_r;
	assign nmi_hold = (state_r == ST_RST_WAIT);
	// data flash never holds; ram mode leaves rom interrupts to the vector in ram
	assign irq_hold = busy & prom_r & rom_exec & (prog_r | ~sie | (state_r != ST_SUSPENDED));
	assign read_ok = (state_r == ST_IDLE) | ((state_r == ST_SUSPENDED) & (rd_block != block_r));

	// ==========================================================
	// assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	logic [15:0] wait_cnt_r; // cycles spent in the suspend wait
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt_r <= 16'h0000;
		end else begin
			wait_cnt_r <= (state_r == ST_SUSP_WAIT) ? wait_cnt_r + 16'h0001 : 16'h0000;
		end
	end

	sequence df_erase_irq_s;
		(state_r == ST_RUN) && !prog_r && !prom_r && sie && irq_ack && !abort_ev;
	endsequence
	sequence rom_erase_irq_s;
		(state_r == ST_RUN) && !prog_r && prom_r && rom_exec && sie && irq_req && !abort_ev && !array_done;
	endsequence

	auto_suspend_a: assert property (df_erase_irq_s |=> esr) else $error("auto suspend request not set");
	suspend_lat_a: assert property ((state_r == ST_SUSP_WAIT) && tmr_done && !array_done && !abort_ev
		|=> (state_r == ST_SUSPENDED) && ($past(wait_cnt_r) == SUSPEND_CYC - 16'h0001))
		else $error("suspend latency wrong");
	read_block_a: assert property ((state_r == ST_SUSPENDED) && (rd_block == block_r) |-> !read_ok)
		else $error("read of suspended block allowed");
	resume_a: assert property ((state_r == ST_SUSPENDED) && !esr && !abort_ev |=> array_run && !array_halt)
		else $error("erase not resumed");
	df_pass_a: assert property (busy && !prom_r |-> !irq_hold) else $error("data flash held interrupt");
	rom_suspend_a: assert property (rom_erase_irq_s |-> irq_hold ##1 esr ##1 (state_r == ST_SUSP_WAIT))
		else $error("rom erase not suspended first");
	rom_hold_a: assert property (busy && prom_r && rom_exec && (prog_r || !sie) |-> irq_hold)
		else $error("rom operation did not hold interrupt");
	abort_a: assert property (abort_ev |=> array_reset && nmi_hold && !array_run ##1 !array_reset)
		else $error("forced abort missing");
	protect_a: assert property (wr_fire && hit(address, CTRL_C_OFS) && !c_r[SIE_BIT] && writedata[SIE_BIT]
		&& (!hist_r[2] || pc_r[SIE_BIT]) |=> !sie) else $error("protected set accepted");
endmodule
`default_nettype wire

//--- verification/flash_array_model.sv
// flash array stand-in: finishes an auto operation after a set number of running cycles
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
	input wire logic clock,
	input wire logic array_run,
	input wire logic array_halt,
	input wire logic array_reset,
	input wire logic [15:0] dur, // running cycles an operation needs
	output logic array_done
);
	logic [15:0] cnt_r; // running cycles spent on the current operation
	initial begin
		cnt_r = 16'h0000;
		array_done = 1'b0;
	end
	// ==========================================================
	// progress counter
	// the count only moves while running and not halted, so a suspend really stretches the operation
	always @(posedge clock) begin
		array_done <= 1'b0;
		if (array_reset || (!array_run && !array_halt)) begin
			cnt_r <= 16'h0000;
		end else if (!array_halt) begin
			if (cnt_r == dur) begin
				array_done <= 1'b1;
				cnt_r <= 16'h0000;
			end else begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

//--- verification/flash_rewrite_interrupt_control_tb.sv
// self-checking bench of the flash rewrite interrupt controller
`timescale 1ns/100ps
`default_nettype none
module flash_rewrite_interrupt_control_tb;
	import flash_rw_pkg::*;
	logic clock, nrst, read, write, irq_req, irq_ack, nmi_event, array_done;
	addr_t address;
	logic [31:0] writedata, readdata, q;
	logic [3:0] byteenable;
	logic waitrequest, irq_hold, nmi_hold, read_ok, array_run, array_prog, array_target_prom, array_halt, array_reset;
	logic [7:0] rd_block, array_block, blk;
	logic [15:0] dur;
	int fail_count, tests_run, rst_seen;
	// behavioural register model: value, last written value, history valid
	logic [7:0] ev [3], pv [3], wm [3], sp [3], cp [3];
	bit hv [3];

	flash_rewrite_interrupt_control DUT (.clock(clock), .nrst(nrst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .irq_req(irq_req), .irq_ack(irq_ack), .nmi_event(nmi_event),
		.irq_hold(irq_hold), .nmi_hold(nmi_hold), .rd_block(rd_block), .read_ok(read_ok),
		.array_done(array_done), .array_run(array_run), .array_prog(array_prog),
		.array_target_prom(array_target_prom), .array_block(array_block), .array_halt(array_halt),
		.array_reset(array_reset));
	flash_array_model partner (.clock(clock), .array_run(array_run), .array_halt(array_halt),
		.array_reset(array_reset), .dur(dur), .array_done(array_done));

	// ==========================================================
	// clock and reset pulse counter
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		if (array_reset === 1'b1) rst_seen++;
	end

	// ==========================================================
	// helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one avalon access; holds the request until the rising edge at which waitrequest is sampled low
	task automatic bus(input logic wr, input addr_t a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clock);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (n >= 50) fail_count++;
		r = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	task automatic rchk(input addr_t a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r & m, e);
	endtask
	// protection model: a protected change needs the opposite value in the previous write
	function automatic logic [7:0] prot(input int i, input logic [7:0] d);
		logic [7:0] n;
		n = (ev[i] & ~wm[i]) | (d & wm[i]);
		for (int b = 0; b < 8; b++) begin
			if (sp[i][b] && n[b] && !ev[i][b] && !(hv[i] && !pv[i][b])) n[b] = 1'b0;
			if (cp[i][b] && !n[b] && ev[i][b] && !(hv[i] && pv[i][b])) n[b] = 1'b1;
		end
		return n;
	endfunction
	// write a control register, update the model and read it back
	task automatic wreg(input int i, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, addr_t'(i * 4), {24'h0, d}, r);
		ev[i] = prot(i, d);
		pv[i] = d;
		hv[i] = 1'b1;
		rchk(addr_t'(i * 4), 32'hffffffff, {24'h0, ev[i]});
	endtask
	task automatic ack;
		@(posedge clock);
		irq_ack <= 1'b1;
		@(posedge clock);
		irq_ack <= 1'b0;
		hv = '{0, 0, 0}; // an acknowledged interrupt breaks any write pair
	endtask
	task automatic nmi;
		@(posedge clock);
		nmi_event <= 1'b1;
		@(posedge clock);
		nmi_event <= 1'b0;
	endtask
	// waits for halt (0), end of restart (1) or end of run (2) and checks the cycle count
	task automatic wait_for(input int which, input int lo, input int hi);
		int n;
		logic c;
		n = 0;
		c = 1'b0;
		while (c !== 1'b1 && n < hi + 10) begin
			@(negedge clock);
			n++;
			c = (which == 0) ? array_halt : (which == 1) ? !nmi_hold : !array_run;
		end
		chk(32'(n >= lo && n <= hi), 32'h1);
	endtask
	task automatic start(input logic [7:0] kind);
		blk = 8'(1 + $urandom % 200);
		dur <= 16'(700 + $urandom % 200); // always longer than the suspend latency
		bus(1'b1, COMMAND_OFS, {16'h0, blk, kind}, q);
		repeat (3) @(negedge clock);
		chk(32'(array_run), 32'h1);
		chk(32'(array_block), 32'(blk));
		chk(32'(array_target_prom), 32'(kind[CMD_PROM_BIT]));
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ==========================================================
	// watchdog: the run needs well under 10000 cycles
	initial begin
		#(40 * 30000);
		fail_count++;
		close_out();
	end

	// ==========================================================
	// main sequence
	initial begin
		nrst = 1'b0; read = 1'b0; write = 1'b0; address = '0; writedata = '0; byteenable = 4'h1;
		irq_req = 1'b0; irq_ack = 1'b0; nmi_event = 1'b0; rd_block = 8'h00; dur = 16'd700;
		fail_count = 0; tests_run = 0; rst_seen = 0;
		ev = '{CTRL_A_RST, CTRL_B_RST, CTRL_C_RST}; pv = '{0, 0, 0}; hv = '{0, 0, 0};
		wm = '{A_WMASK, B_WMASK, C_WMASK}; sp = '{A_SETP, B_SETP, C_SETP}; cp = '{A_CLRP, B_CLRP, C_CLRP};
		void'($urandom(32'h91033947));
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		repeat (3) @(posedge clock);
		// reset values, unmapped address reads zero
		for (int i = 0; i < 6; i++) rchk(addr_t'(i * 4), 32'hffffffff, 32'h0);
		chk(32'(read_ok), 32'h1);
		$display("test reset done");
		// protected bits: lone write refused, pairs accepted
		wreg(2, 8'h04);
		wreg(2, 8'h00);
		wreg(2, 8'h04);
		wreg(0, 8'h00);
		wreg(0, 8'h02);
		// a write without its low byte enable changes nothing
		byteenable <= 4'h0;
		bus(1'b1, CTRL_A_OFS, 32'h0, q);
		byteenable <= 4'h1;
		rchk(CTRL_A_OFS, 32'hff, {24'h0, ev[0]});
		wreg(1, 8'h00);
		wreg(1, 8'hf0);
		wreg(1, 8'hf0);
		ack();
		wreg(1, 8'h00);
		wreg(1, 8'hf0);
		wreg(1, 8'h00);
		$display("test protection done");
		// data erase without auto-suspend: software suspends, reads elsewhere, resumes
		wreg(2, 8'h00);
		start(8'h01);
		ack();
		repeat (3) @(negedge clock);
		chk(32'(irq_hold), 32'h0);
		rchk(CTRL_C_OFS, 32'hff, {24'h0, ev[2]});
		nmi();
		repeat (3) @(negedge clock);
		chk(32'(array_run), 32'h1);
		chk(32'(rst_seen), 32'h0);
		wreg(2, 8'h02);
		wait_for(0, int'(SUSPEND_CYC) - 3, int'(SUSPEND_CYC) + 5);
		rchk(STATUS_OFS, 32'h2, 32'h2);
		rd_block <= blk;
		@(negedge clock);
		chk(32'(read_ok), 32'h0);
		@(posedge clock);
		rd_block <= blk + 8'h01;
		@(negedge clock);
		chk(32'(read_ok), 32'h1);
		wreg(2, 8'h00);
		repeat (3) @(negedge clock);
		chk(32'(array_halt), 32'h0);
		chk(32'(array_run), 32'h1);
		wait_for(2, 1, 1000);
		rchk(STATUS_OFS, 32'h8, 32'h8);
		$display("test software suspend done");
		// data erase with auto-suspend on acknowledge
		wreg(2, 8'h04);
		start(8'h01);
		ack();
		ev[2][ESR_BIT] = 1'b1;
		wait_for(0, int'(SUSPEND_CYC) - 3, int'(SUSPEND_CYC) + 5);
		rchk(CTRL_C_OFS, 32'hff, {24'h0, ev[2]});
		wreg(2, 8'h04);
		wait_for(2, 1, 1000);
		$display("test auto suspend done");
		// program rom erase in rom mode: hold, suspend first, then forced abort
		wreg(1, 8'h02);
		start(8'h05);
		chk(32'(irq_hold), 32'h1);
		@(posedge clock);
		irq_req <= 1'b1;
		wait_for(0, int'(SUSPEND_CYC) - 3, int'(SUSPEND_CYC) + 5);
		chk(32'(irq_hold), 32'h0);
		@(posedge clock);
		irq_req <= 1'b0;
		ev[2][ESR_BIT] = 1'b1;
		wreg(2, 8'h04);
		repeat (3) @(negedge clock);
		chk(32'(irq_hold), 32'h1);
		nmi();
		wait_for(1, int'(RESTART_CYC) - 2, int'(RESTART_CYC) + 4);
		chk(32'(rst_seen), 32'h1);
		rchk(STATUS_OFS, 32'h4, 32'h4);
		$display("test abort done");
		// erase repeated after the abort, then a rom program with interrupts held
		start(8'h05);
		wait_for(2, 1, 1000);
		rchk(STATUS_OFS, 32'h8, 32'h8);
		start(8'h07);
		@(posedge clock);
		irq_req <= 1'b1;
		repeat (3) @(negedge clock);
		chk(32'(irq_hold), 32'h1);
		chk(32'(array_prog), 32'h1);
		wait_for(2, 1, 1000);
		chk(32'(irq_hold), 32'h0);
		rchk(CTRL_C_OFS, 32'hff, {24'h0, ev[2]});
		irq_req <= 1'b0;
		$display("test rom program done");
		// ram mode: a rom erase leaves interrupts to the ram vector, a non-maskable event still aborts
		wreg(1, 8'h00);
		start(8'h05);
		@(posedge clock);
		irq_req <= 1'b1;
		repeat (3) @(negedge clock);
		chk(32'(irq_hold), 32'h0);
		chk(32'(array_halt), 32'h0);
		rchk(CTRL_C_OFS, 32'hff, {24'h0, ev[2]});
		irq_req <= 1'b0;
		nmi();
		wait_for(1, int'(RESTART_CYC) - 2, int'(RESTART_CYC) + 4);
		chk(32'(rst_seen), 32'h2);
		rchk(STATUS_OFS, 32'h4, 32'h4);
		$display("test ram mode done");
		close_out();
	end
endmodule
`default_nettype wire
